// ==== hw/caoc_top.sv ====
// Command interpreter that loads converter codes from received bank command frames.
`default_nettype none
module caoc_top #(
	parameter int NUM_BANKS = caoc_pkg::NUM_BANKS,
	parameter int NCH       = NUM_BANKS * caoc_pkg::CHANS_PER_BANK
) (
	input  wire logic                                sys_clk,
	input  wire logic                                rstn,
	input  wire logic                                wb_cyc_i,
	input  wire logic                                wb_stb_i,
	input  wire logic                                wb_we_i,
	input  wire logic [caoc_pkg::WB_ADR_W-1:0]       wb_adr_i,
	input  wire logic [caoc_pkg::WB_DAT_W-1:0]       wb_dat_i,
	input  wire logic [caoc_pkg::WB_SEL_W-1:0]       wb_sel_i,
	output logic      [caoc_pkg::WB_DAT_W-1:0]       wb_dat_o,
	output logic                                     wb_ack_o,
	input  wire logic                                frm_valid,
	input  wire logic [caoc_pkg::ID_W-1:0]           frm_id,
	input  wire logic [caoc_pkg::DLC_W-1:0]          frm_dlc,
	input  wire logic [caoc_pkg::DATA_W-1:0]         frm_data,
	output logic      [NCH*caoc_pkg::CODE_W-1:0]     dac_code,
	output logic                                     err_rsp_valid,
	output logic      [caoc_pkg::ID_W-1:0]           err_rsp_id
);
	localparam int CPB    = caoc_pkg::CHANS_PER_BANK;
	localparam int CW     = caoc_pkg::CODE_W;
	localparam int BANK_W = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic        enable;
		logic [28:0] base_id;
		logic [15:0] frame_cnt;
		logic [15:0] err_cnt;
		logic        err_pulse;
		logic [28:0] err_id;
	} caoc_top_s;

	caoc_top_s st;
	caoc_top_s next_st;

	logic [2:0]        chan_mask;
	logic [3:0]        dlc_need;
	logic [29:0]       id_ext;
	logic [29:0]       base_ext;
	logic [28:0]       bank_off;
	logic [BANK_W-1:0] bank_idx;
	logic              bank_hit;
	logic              frame_ok;
	logic              frame_bad;
	logic [NCH-1:0]    chan_load;
	logic [5:0]        word_idx;
	logic [5:0]        code_idx;
	logic [31:0]       wr_word;
	logic [31:0]       rd_word;

	// Channel mask sits in the low three bits of the first payload byte.
	assign chan_mask = frm_data[caoc_pkg::MASK_MSB-5 -: 3];

	// Payload length needed to reach the highest selected channel's pair.
	always_comb begin
		if (chan_mask[2]) begin
			dlc_need = caoc_pkg::DLC_CH3;
		end else if (chan_mask[1]) begin
			dlc_need = caoc_pkg::DLC_CH2;
		end else if (chan_mask[0]) begin
			dlc_need = caoc_pkg::DLC_CH1;
		end else begin
			dlc_need = caoc_pkg::DLC_MASK_ONLY;
		end
	end

	// One identifier per bank, counting up from the base identifier.
	assign id_ext   = {1'b0, frm_id};
	assign base_ext = {1'b0, st.base_id};
	assign bank_hit = frm_valid && st.enable && (id_ext >= base_ext)
		&& (id_ext < base_ext + 30'(NUM_BANKS));
	assign bank_off = frm_id - st.base_id;
	assign bank_idx = bank_off[BANK_W-1:0];
	assign frame_ok  = bank_hit && (chan_mask != 3'h0) && (frm_dlc >= dlc_need);
	assign frame_bad = bank_hit && !frame_ok;

	// Load strobes per channel; only masked channels of the addressed bank change.
	always_comb begin
		chan_load = '0;
		for (int b = 0; b < NUM_BANKS; b++) begin
			for (int c = 0; c < CPB; c++) begin
				if (frame_ok && (bank_idx == BANK_W'(b)) && chan_mask[c]) begin
					chan_load[b*CPB+c] = 1'b1;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_chan
			localparam int CI = g % CPB;
			// Pair for channel n follows the mask byte, first byte is the high half.
			caoc_chan_reg #(
				.RESET_CODE(caoc_pkg::CODE_RESET)
			) u_chan (
				.sys_clk  (sys_clk),
				.rstn     (rstn),
				.load     (chan_load[g]),
				.load_code(frm_data[caoc_pkg::CODE0_MSB-CI*CW -: CW]),
				.code     (dac_code[g*CW +: CW])
			);

			a_chan_load: assert property (@(posedge sys_clk) disable iff (!rstn)
				chan_load[g] |=> dac_code[g*CW +: CW] == $past(frm_data[caoc_pkg::CODE0_MSB-CI*CW -: CW]))
				else $error("Channel code does not match the received byte pair.");

			a_chan_unmasked: assert property (@(posedge sys_clk) disable iff (!rstn)
				(frm_valid && !chan_mask[CI]) |=> $stable(dac_code[g*CW +: CW]))
				else $error("Unselected channel code changed.");

			a_bank_select: assert property (@(posedge sys_clk) disable iff (!rstn)
				(frm_valid && !(frame_ok && (bank_idx == BANK_W'(g / CPB)))) |=> $stable(dac_code[g*CW +: CW]))
				else $error("Code of a bank not addressed by the frame changed.");
		end
	endgenerate

	// Register bus read data and write data after byte lanes.
	assign word_idx = wb_adr_i[7:2];
	assign code_idx = word_idx - caoc_pkg::OFS_CODE0[7:2];

	always_comb begin
		rd_word = 32'h00000000;
		case (wb_adr_i)
			caoc_pkg::OFS_CTRL: begin
				rd_word[caoc_pkg::CTRL_EN_BIT] = st.enable;
			end
			caoc_pkg::OFS_BASE_ID: begin
				rd_word = {3'h0, st.base_id};
			end
			caoc_pkg::OFS_STATUS: begin
				rd_word[caoc_pkg::STAT_FRM_LSB +: 16] = st.frame_cnt;
				rd_word[caoc_pkg::STAT_ERR_LSB +: 16] = st.err_cnt;
			end
			caoc_pkg::OFS_LAST_ERR: begin
				rd_word = {3'h0, st.err_id};
			end
			default: begin
				if ((wb_adr_i[1:0] == 2'h0) && (word_idx >= caoc_pkg::OFS_CODE0[7:2])
					&& (32'(code_idx) < NCH)) begin
					rd_word = {16'h0000, dac_code[code_idx*CW +: CW]};
				end
			end
		endcase
	end

	always_comb begin
		wr_word = (wb_adr_i == caoc_pkg::OFS_CTRL) ? {31'h0, st.enable} : {3'h0, st.base_id};
		for (int i = 0; i < caoc_pkg::WB_SEL_W; i++) begin
			if (wb_sel_i[i]) begin
				wr_word[i*8 +: 8] = wb_dat_i[i*8 +: 8];
			end
		end
	end

	always_comb begin
		next_st = st;
		next_st.err_pulse = 1'b0;
		next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
		if (wb_cyc_i && wb_stb_i && !st.ack) begin
			next_st.rdata = rd_word;
		end
		// Writes take effect at the edge where the master sees the acknowledge.
		if (wb_cyc_i && wb_stb_i && st.ack && wb_we_i) begin
			if (wb_adr_i == caoc_pkg::OFS_CTRL) begin
				next_st.enable = wr_word[caoc_pkg::CTRL_EN_BIT];
			end else if (wb_adr_i == caoc_pkg::OFS_BASE_ID) begin
				next_st.base_id = wr_word[28:0];
			end
		end
		if (frame_ok) begin
			next_st.frame_cnt = st.frame_cnt + 16'h0001;
		end
		if (frame_bad) begin
			next_st.err_pulse = 1'b1;
			next_st.err_id    = frm_id;
			next_st.err_cnt   = st.err_cnt + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st.ack       <= 1'b0;
			st.rdata     <= 32'h00000000;
			st.enable    <= caoc_pkg::ENABLE_RESET;
			st.base_id   <= caoc_pkg::DEF_BASE_ID;
			st.frame_cnt <= 16'h0000;
			st.err_cnt   <= 16'h0000;
			st.err_pulse <= 1'b0;
			st.err_id    <= 29'h0000000;
		end else begin
			st <= next_st;
		end
	end

	assign wb_ack_o      = st.ack;
	assign wb_dat_o      = st.rdata;
	assign err_rsp_valid = st.err_pulse;
	assign err_rsp_id    = st.err_id;

	sequence s_zero_mask_frame;
		bank_hit && (chan_mask == 3'h0);
	endsequence

	sequence s_error_reply;
		err_rsp_valid && (err_rsp_id == $past(frm_id));
	endsequence

	a_zero_mask_err: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_zero_mask_frame |=> s_error_reply)
		else $error("Zero mask frame gave no error response.");

	a_zero_mask_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_zero_mask_frame |=> $stable(dac_code))
		else $error("Zero mask frame changed a code.");

	a_err_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
		err_rsp_valid |-> $past(frame_bad))
		else $error("Error response without a rejected frame.");

	a_foreign_id: assert property (@(posedge sys_clk) disable iff (!rstn)
		(frm_valid && !bank_hit) |=> $stable(dac_code) && !err_rsp_valid)
		else $error("Frame outside the bank identifiers had an effect.");

	a_bank_one_half: assert property (@(posedge sys_clk) disable iff (!rstn)
		(frm_valid && st.enable && (st.base_id == caoc_pkg::DEF_BASE_ID) && (frm_id == 29'h0000041)
		&& (frm_data[63:40] == 24'h017fff) && (frm_dlc >= 4'h3)) |=> dac_code[15:0] == 16'h7fff)
		else $error("Bank one channel one not set to half scale.");

	a_last_bank: assert property (@(posedge sys_clk) disable iff (!rstn)
		(frame_ok && (frm_id == st.base_id + 29'(NUM_BANKS-1)) && chan_mask[2])
		|=> dac_code[(NCH-1)*CW +: CW] == $past(frm_data[23:8]))
		else $error("Last bank third channel not loaded.");

	a_ack_once: assert property (@(posedge sys_clk) disable iff (!rstn)
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held for more than one cycle.");

	sequence s_bus_request;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence s_short_frame;
		bank_hit && (chan_mask != 3'h0) && (frm_dlc < dlc_need);
	endsequence

	sequence s_base_write;
		wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
		&& (wb_adr_i == caoc_pkg::OFS_BASE_ID) && (wb_sel_i == 4'hf);
	endsequence

	a_ack_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_bus_request |=> wb_ack_o)
		else $error("Bus request was not acknowledged in the next cycle.");

	a_ack_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("Acknowledge without a bus request.");

	a_short_frame: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_short_frame |=> $stable(dac_code) && err_rsp_valid)
		else $error("Frame too short for its selected channels was not rejected.");

	a_reply_id: assert property (@(posedge sys_clk) disable iff (!rstn)
		frame_bad |=> err_rsp_id == $past(frm_id))
		else $error("Error response carries the wrong identifier.");

	a_err_id_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		!frame_bad |=> $stable(err_rsp_id))
		else $error("Error identifier changed without a rejected frame.");

	a_good_no_err: assert property (@(posedge sys_clk) disable iff (!rstn)
		frame_ok |=> !err_rsp_valid)
		else $error("Accepted frame raised an error response.");

	a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
		(frm_valid && !st.enable) |=> $stable(dac_code) && !err_rsp_valid)
		else $error("Frame had an effect while the interpreter was disabled.");

	a_base_write: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_base_write |=> st.base_id == $past(wb_dat_i[28:0]))
		else $error("Base identifier write did not land.");

	a_frame_count: assert property (@(posedge sys_clk) disable iff (!rstn)
		frame_ok |=> st.frame_cnt == $past(st.frame_cnt) + 16'h0001)
		else $error("Good frame count did not advance.");

	a_err_count: assert property (@(posedge sys_clk) disable iff (!rstn)
		frame_bad |=> st.err_cnt == $past(st.err_cnt) + 16'h0001)
		else $error("Error count did not advance.");
endmodule
`default_nettype wire

// ==== shared/caoc_pkg.sv ====
// Package with the constants shared by the analog output command interpreter.
`default_nettype none
package caoc_pkg;
	localparam int          NUM_BANKS      = 8;
	localparam int          CHANS_PER_BANK = 3;
	localparam int          CODE_W         = 16;
	localparam int          ID_W           = 29;
	localparam int          DLC_W          = 4;
	localparam int          DATA_W         = 64;
	localparam int          WB_ADR_W       = 8;
	localparam int          WB_DAT_W       = 32;
	localparam int          WB_SEL_W       = 4;
	localparam logic [28:0] DEF_BASE_ID    = 29'h0000041;
	localparam logic [15:0] CODE_RESET     = 16'h0000;
	localparam logic        ENABLE_RESET   = 1'b1;
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_BASE_ID    = 8'h04;
	localparam logic [7:0]  OFS_STATUS     = 8'h08;
	localparam logic [7:0]  OFS_LAST_ERR   = 8'h0c;
	localparam logic [7:0]  OFS_CODE0      = 8'h40;
	localparam int          CTRL_EN_BIT    = 0;
	localparam int          STAT_FRM_LSB   = 0;
	localparam int          STAT_ERR_LSB   = 16;
	localparam int          MASK_MSB       = 63;
	localparam int          CODE0_MSB      = 55;
	localparam logic [3:0]  DLC_MASK_ONLY  = 4'h1;
	localparam logic [3:0]  DLC_CH1        = 4'h3;
	localparam logic [3:0]  DLC_CH2        = 4'h5;
	localparam logic [3:0]  DLC_CH3        = 4'h7;
endpackage
`default_nettype wire

// ==== hw/caoc_chan_reg.sv ====
// Holding register for one channel's converter code.
`default_nettype none
module caoc_chan_reg #(
	parameter logic [15:0] RESET_CODE = caoc_pkg::CODE_RESET
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        load,
	input  wire logic [15:0] load_code,
	output logic      [15:0] code
);
	typedef struct packed {
		logic [15:0] code;
	} caoc_chan_s;

	caoc_chan_s st;
	caoc_chan_s next_st;

	always_comb begin
		next_st = st;
		if (load) begin
			next_st.code = load_code;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st.code <= RESET_CODE;
		end else begin
			st <= next_st;
		end
	end

	assign code = st.code;

	a_chan_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		!load |=> $stable(code))
		else $error("Channel code changed without a load.");
endmodule
`default_nettype wire

// ==== tb/caoc_host_model.sv ====
// Model of the bus host that sends bank command frames.
`default_nettype none
module caoc_host_model (
	input  wire logic        sys_clk,
	output var  logic        frm_valid,
	output var  logic [28:0] frm_id,
	output var  logic [3:0]  frm_dlc,
	output var  logic [63:0] frm_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frm_valid = 1'b0;
		frm_id = 29'h0000000;
		frm_dlc = 4'h0;
		frm_data = 64'h0;
	end
	// Code is the share of full scale times the largest code, with the fraction dropped.
	function automatic logic [15:0] mv_code(input int mv);
		return 16'((mv * 65535) / 5000);
	endfunction
	// Sends one frame; between frames the lines carry inverted, stale-looking values.
	task automatic send(input logic [28:0] id, input logic [3:0] dlc, input logic [7:0] mask,
		input int v1, input int v2, input int v3);
		@(posedge sys_clk);
		frm_valid <= 1'b1;
		frm_id <= id;
		frm_dlc <= dlc;
		frm_data <= {mask, mv_code(v1), mv_code(v2), mv_code(v3), 8'h00};
		@(posedge sys_clk);
		frm_valid <= 1'b0;
		frm_id <= ~id;
		frm_dlc <= ~dlc;
		frm_data <= ~frm_data;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_caoc_top.sv ====
// Self-checking bench for the analog output command interpreter.
`default_nettype none
module tb_caoc_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [28:0] id; logic [3:0] dlc; logic [7:0] mask; int v1; int v2; int v3; logic err;} caoc_row_s;
	logic         sys_clk = 1'b0;
	logic         rstn = 1'b0;
	logic         cyc = 1'b0;
	logic         we = 1'b0;
	logic [7:0]   adr = 8'h00;
	logic [31:0]  wdat = 32'h0;
	logic [31:0]  rd, dat_o;
	logic         ack, fv, erv;
	logic [28:0]  fid, erid;
	logic [3:0]   fdlc;
	logic [63:0]  fdat;
	logic [383:0] dac;
	logic [15:0]  exp_c [24];
	int           miscompares = 0;
	int           n_compared = 0;
	int           b;
	caoc_row_s rows [12] = '{
		'{29'h41, 4'h3, 8'h00, 2500, 0, 0, 1'b1},
		'{29'h41, 4'h3, 8'h01, 2500, 0, 0, 1'b0},
		'{29'h41, 4'h3, 8'h01, 5000, 0, 0, 1'b0},
		'{29'h41, 4'h3, 8'h01, 0, 0, 0, 1'b0},
		'{29'h41, 4'h5, 8'h02, 0, 2500, 0, 1'b0},
		'{29'h41, 4'h7, 8'h04, 0, 0, 5000, 1'b0},
		'{29'h42, 4'h3, 8'h01, 2500, 0, 0, 1'b0},
		'{29'h45, 4'h5, 8'h03, 1000, 2500, 0, 1'b0},
		'{29'h48, 4'h7, 8'h07, 1000, 3750, 5000, 1'b0},
		'{29'h49, 4'h3, 8'h01, 5000, 0, 0, 1'b0},
		'{29'h43, 4'h3, 8'h02, 0, 2500, 0, 1'b1},
		'{29'h44, 4'h7, 8'hf8, 3750, 0, 0, 1'b1}
	};
	always #5 sys_clk = ~sys_clk;
	caoc_host_model host (.sys_clk(sys_clk), .frm_valid(fv), .frm_id(fid), .frm_dlc(fdlc), .frm_data(fdat));
	caoc_top dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack), .frm_valid(fv), .frm_id(fid),
		.frm_dlc(fdlc), .frm_data(fdat), .dac_code(dac), .err_rsp_valid(erv), .err_rsp_id(erid));
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_all();
		for (int k = 0; k < 24; k++) cmp(exp_c[k], dac[k*16+:16]);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
		if (n >= 50) miscompares++;
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#200us;
		miscompares++;
		finish_test();
	end
	initial begin
		for (int k = 0; k < 24; k++) exp_c[k] = 16'h0000;
		repeat (16) @(posedge sys_clk);
		chk_all();
		cmp(32'h0, 32'(erv));
		cmp(32'h0, 32'(erid));
		rstn <= 1'b1;
		foreach (rows[i]) begin
			host.send(rows[i].id, rows[i].dlc, rows[i].mask, rows[i].v1, rows[i].v2, rows[i].v3);
			#1;
			cmp(32'(rows[i].err), 32'(erv));
			if (rows[i].err) cmp(32'(rows[i].id), 32'(erid));
			b = int'(rows[i].id) - 'h41;
			if (!rows[i].err && b >= 0 && b < 8) begin
				if (rows[i].mask[0]) exp_c[b*3] = host.mv_code(rows[i].v1);
				if (rows[i].mask[1]) exp_c[b*3+1] = host.mv_code(rows[i].v2);
				if (rows[i].mask[2]) exp_c[b*3+2] = host.mv_code(rows[i].v3);
			end
			chk_all();
		end
		host.send(29'h41, 4'h3, 8'h01, 2500, 0, 0);
		#1;
		exp_c[0] = 16'h7fff;
		cmp(32'h7fff, 32'(dac[15:0]));
		wb(1'b0, 8'h9c, 32'h0);
		cmp({16'h0, exp_c[23]}, rd);
		wb(1'b0, 8'h20, 32'h0);
		cmp(32'h0, rd);
		wb(1'b1, 8'h00, 32'h0);
		host.send(29'h42, 4'h3, 8'h01, 5000, 0, 0);
		#1;
		cmp(32'h0, 32'(erv));
		chk_all();
		wb(1'b1, 8'h04, 32'h100);
		wb(1'b1, 8'h00, 32'h1);
		wb(1'b0, 8'h04, 32'h0);
		cmp(32'h100, rd);
		host.send(29'h107, 4'h3, 8'h01, 5000, 0, 0);
		#1;
		exp_c[21] = 16'hffff;
		chk_all();
		wb(1'b0, 8'h08, 32'h0);
		cmp(32'h0003000a, rd);
		wb(1'b0, 8'h0c, 32'h0);
		cmp(32'h44, rd);
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		for (int k = 0; k < 24; k++) exp_c[k] = 16'h0000;
		chk_all();
		cmp(32'h0, 32'(erv));
		cmp(32'h0, 32'(erid));
		@(posedge sys_clk);
		rstn <= 1'b1;
		host.send(29'h48, 4'h7, 8'h04, 0, 0, 2500);
		#1;
		exp_c[23] = 16'h7fff;
		chk_all();
		finish_test();
	end
endmodule
`default_nettype wire
